/* rcw_pkg.sv */
// Shared constants for the radio configuration and wake timer register bank
package rcw_pkg;
    // ----------------------------------------
    // Bus shape
    // ----------------------------------------
    localparam int ADDR_W = 10;
    localparam int DATA_W = 8;

    // ----------------------------------------
    // Register offsets
    // ----------------------------------------
    localparam logic [9:0] OFF_BUF_CFG  = 10'h107;
    localparam logic [9:0] OFF_RX_DLY   = 10'h109;
    localparam logic [9:0] OFF_TX_DLY   = 10'h10A;
    localparam logic [9:0] OFF_DLY_EXT  = 10'h10B;
    localparam logic [9:0] OFF_PKT_FMT  = 10'h13E;
    localparam logic [9:0] OFF_FREQ_LO  = 10'h300;
    localparam logic [9:0] OFF_FREQ_MID = 10'h301;
    localparam logic [9:0] OFF_FREQ_HI  = 10'h302;
    localparam logic [9:0] OFF_TX_MOD   = 10'h306;
    localparam logic [9:0] OFF_PWR      = 10'h30C;
    localparam logic [9:0] OFF_LQI      = 10'h30D;
    localparam logic [9:0] OFF_TX_PTR   = 10'h314;
    localparam logic [9:0] OFF_RX_PTR   = 10'h315;
    localparam logic [9:0] OFF_DIV      = 10'h316;
    localparam logic [9:0] OFF_SLEEP    = 10'h317;
    localparam logic [9:0] OFF_RLD_HI   = 10'h318;
    localparam logic [9:0] OFF_RLD_LO   = 10'h319;
    localparam logic [9:0] OFF_WT_CTRL  = 10'h31A;
    localparam logic [9:0] OFF_WT_STAT  = 10'h31B;

    // ----------------------------------------
    // Reset values
    // ----------------------------------------
    localparam logic [7:0]  RST_RX_DLY  = 8'hC0;
    localparam logic [7:0]  RST_TX_DLY  = 8'hC0;
    localparam logic [7:0]  RST_EXT     = 8'h00;
    localparam logic [7:0]  RST_PKT     = 8'h00;
    localparam logic [23:0] RST_FREQ    = 24'h03A980;
    localparam logic        RST_PREEMP  = 1'b1;
    localparam logic [7:0]  RST_TX_PTR  = 8'h80;
    localparam logic [7:0]  RST_RX_PTR  = 8'h00;
    localparam logic [2:0]  RST_DIV     = 3'h0;
    localparam logic [3:0]  RST_SLEEP   = 4'h0;
    localparam logic [15:0] RST_RELOAD  = 16'h0000;

    // ----------------------------------------
    // Field positions
    // ----------------------------------------
    localparam int BIT_DLY_OFF  = 7;
    localparam int BIT_PREEMP   = 0;
    localparam int DIV_MSB      = 2;
    localparam int SLEEP_MSB    = 6;
    localparam int SLEEP_LSB    = 3;
    localparam int BIT_WAKE_EN  = 0;
    localparam int BIT_CAL      = 1;
    localparam int BIT_FLAG_CLR = 0;
    localparam int BIT_TOFLAG   = 1;
    localparam int BIT_COLD     = 2;

    // ----------------------------------------
    // Mode codes
    // ----------------------------------------
    localparam logic [7:0] PKT_STD    = 8'h00;
    localparam logic [7:0] PKT_RAW_RX = 8'h02;
    localparam logic [7:0] PKT_RAW_TX = 8'h03;
    localparam logic [3:0] SLEEP_KEEP_MEM    = 4'h1;
    localparam logic [3:0] SLEEP_KEEP_XTAL   = 4'h4;
    localparam logic [3:0] SLEEP_KEEP_MEM_XT = 4'h5;
    localparam logic [3:0] SLEEP_KEEP_MEM_RC = 4'hB;

    // ----------------------------------------
    // Timing
    // ----------------------------------------
    localparam int CLK_PERIOD_NS = 20;
    localparam int DLY_UNIT_NS   = 1000;
    localparam int EXT_UNIT_US   = 4;
    localparam int CYC_PER_US    = (DLY_UNIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    function automatic logic [16:0] rcw_div_ratio(input logic [2:0] code);
        case (code)
            3'h0: rcw_div_ratio = 17'h00001;
            3'h1: rcw_div_ratio = 17'h00004;
            3'h2: rcw_div_ratio = 17'h00008;
            3'h3: rcw_div_ratio = 17'h00010;
            3'h4: rcw_div_ratio = 17'h00080;
            3'h5: rcw_div_ratio = 17'h00400;
            3'h6: rcw_div_ratio = 17'h02000;
            default: rcw_div_ratio = 17'h10000;
        endcase
    endfunction : rcw_div_ratio
endpackage : rcw_pkg

/* rcw_start_delay.sv */
// Receive and transmit start delay timer in microsecond steps
module rcw_start_delay
    import rcw_pkg::*;
(
    input  wire logic       core_clk,
    input  wire logic       srst,
    input  wire logic       clk_en,
    input  wire logic       rx_cmd,
    input  wire logic       tx_cmd,
    input  wire logic [7:0] rx_delay_us,
    input  wire logic [7:0] tx_delay_us,
    input  wire logic [7:0] delay_ext,
    input  wire logic       delay_off,
    output logic            rx_go,
    output logic            tx_go
);
    typedef enum logic [1:0] {SD_IDLE = 2'b01, SD_WAIT = 2'b10} rcw_sd_e;

    localparam logic [5:0] US_LAST = 6'(CYC_PER_US - 1);

    rcw_sd_e     state;
    logic [5:0]  us_cnt;
    logic [10:0] remain;
    logic        for_tx;
    logic [10:0] total;

    // Extension in 4 us steps on top of the base delay
    assign total = {3'h0, (tx_cmd ? tx_delay_us : rx_delay_us)}
                 + {1'b0, delay_ext, 2'b00};

    always_ff @(posedge core_clk)
    begin
        if (srst)
        begin
            state  <= SD_IDLE;
            us_cnt <= 6'h00;
            remain <= 11'h000;
            for_tx <= 1'b0;
            rx_go  <= 1'b0;
            tx_go  <= 1'b0;
        end
        else if (clk_en)
        begin
            rx_go <= 1'b0;
            tx_go <= 1'b0;
            if (rx_cmd || tx_cmd)
            begin
                // A new command restarts the wait
                for_tx <= tx_cmd;
                us_cnt <= 6'h00;
                if (delay_off || total == 11'h000)
                begin
                    state <= SD_IDLE;
                    rx_go <= ~tx_cmd;
                    tx_go <= tx_cmd;
                end
                else
                begin
                    state  <= SD_WAIT;
                    remain <= total;
                end
            end
            else
            begin
                case (state)
                    SD_WAIT:
                    begin
                        if (us_cnt == US_LAST)
                        begin
                            us_cnt <= 6'h00;
                            remain <= remain - 11'h001;
                            if (remain == 11'h001)
                            begin
                                state <= SD_IDLE;
                                rx_go <= ~for_tx;
                                tx_go <= for_tx;
                            end
                        end
                        else
                            us_cnt <= us_cnt + 6'h01;
                    end
                    default: state <= SD_IDLE;
                endcase
            end
        end
    end

    a_bypass_go : assert property (@(posedge core_clk) disable iff (srst)
        clk_en && rx_cmd && !tx_cmd && delay_off |=> rx_go)
        else $error("bypassed receive start not immediate");
    a_delay_wait : assert property (@(posedge core_clk) disable iff (srst)
        clk_en && tx_cmd && !delay_off && tx_delay_us != 8'h00 |=> !tx_go [*2])
        else $error("transmit start came before the delay");
endmodule : rcw_start_delay

/* rcw_regs.sv */
// Radio configuration and wake timer register bank with host register port
//
// Strobed register access was chosen for this implementation.
module rcw_regs
    import rcw_pkg::*;
(
    input  wire logic              core_clk,
    input  wire logic              srst,
    input  wire logic              clk_en,
    input  wire logic [ADDR_W-1:0] reg_addr,
    input  wire logic [DATA_W-1:0] reg_wdata,
    input  wire logic              reg_wr,
    input  wire logic              reg_rd,
    output logic      [DATA_W-1:0] reg_rdata,
    input  wire logic              receive_command,
    input  wire logic              transmit_command,
    input  wire logic [6:0]        controller_owned_bits,
    input  wire logic [7:0]        rssi_dbm,
    input  wire logic [7:0]        link_quality,
    input  wire logic              meas_valid,
    input  wire logic              wake_timeout_in,
    output logic                   rx_search_start,
    output logic                   tx_state_start,
    output logic      [7:0]        packet_format_select,
    output logic      [23:0]       channel_frequency_word,
    output logic                   preemphasis_enable,
    output logic      [7:0]        tx_buffer_base,
    output logic      [7:0]        rx_buffer_base,
    output logic      [16:0]       wake_prescale_ratio,
    output logic      [3:0]        sleep_retention_mode,
    output logic                   timeout_wake_enable,
    output logic      [15:0]       wake_reload,
    output logic                   rc_clock_calibrate_enable,
    output logic                   wake_request,
    output logic                   timeout_flag,
    output logic                   cold_start_flag
);
    // ----------------------------------------
    // Decode
    // ----------------------------------------
    function automatic logic wr_at(input logic [9:0] off);
        wr_at = reg_wr && (reg_addr == off);
    endfunction : wr_at

    function automatic logic pkt_code_ok(input logic [7:0] c);
        pkt_code_ok = (c == PKT_STD) || (c == PKT_RAW_RX) || (c == PKT_RAW_TX);
    endfunction : pkt_code_ok

    function automatic logic sleep_code_ok(input logic [3:0] c);
        sleep_code_ok = (c == SLEEP_KEEP_MEM) || (c == SLEEP_KEEP_XTAL)
                     || (c == SLEEP_KEEP_MEM_XT) || (c == SLEEP_KEEP_MEM_RC);
    endfunction : sleep_code_ok

    logic [7:0] receive_start_delay;
    logic [7:0] transmit_start_delay;
    logic [7:0] start_delay_extension;
    logic       start_delay_off;
    logic [7:0] input_power_readout;
    logic [7:0] link_quality_readout;
    logic [2:0] div_stage;
    logic [2:0] div_code;
    logic [7:0] reload_hi_stage;
    logic [2:0] tmo_sync;
    logic       timeout_evt;
    logic       clear_flags;
    logic [7:0] next_rdata;

    // ----------------------------------------
    // Start delays and radio setup
    // ----------------------------------------
    always_ff @(posedge core_clk)
    begin
        if (srst)
        begin
            receive_start_delay   <= RST_RX_DLY;
            transmit_start_delay  <= RST_TX_DLY;
            start_delay_extension <= RST_EXT;
            start_delay_off       <= 1'b0;
        end
        else if (clk_en)
        begin
            if (wr_at(OFF_RX_DLY))
                receive_start_delay <= reg_wdata;
            if (wr_at(OFF_TX_DLY))
                transmit_start_delay <= reg_wdata;
            if (wr_at(OFF_DLY_EXT))
                start_delay_extension <= reg_wdata;
            if (wr_at(OFF_BUF_CFG))
                start_delay_off <= reg_wdata[BIT_DLY_OFF];
        end
    end

    rcw_start_delay u_start_delay (
        .core_clk    (core_clk),
        .srst        (srst),
        .clk_en      (clk_en),
        .rx_cmd      (receive_command),
        .tx_cmd      (transmit_command),
        .rx_delay_us (receive_start_delay),
        .tx_delay_us (transmit_start_delay),
        .delay_ext   (start_delay_extension),
        .delay_off   (start_delay_off),
        .rx_go       (rx_search_start),
        .tx_go       (tx_state_start)
    );

    always_ff @(posedge core_clk)
    begin
        if (srst)
        begin
            packet_format_select   <= RST_PKT;
            channel_frequency_word <= RST_FREQ;
            preemphasis_enable     <= RST_PREEMP;
            tx_buffer_base         <= RST_TX_PTR;
            rx_buffer_base         <= RST_RX_PTR;
        end
        else if (clk_en)
        begin
            // Reserved format codes are dropped so the radio never sees them
            if (wr_at(OFF_PKT_FMT) && pkt_code_ok(reg_wdata))
                packet_format_select <= reg_wdata;
            if (wr_at(OFF_FREQ_LO))
                channel_frequency_word[7:0] <= reg_wdata;
            if (wr_at(OFF_FREQ_MID))
                channel_frequency_word[15:8] <= reg_wdata;
            if (wr_at(OFF_FREQ_HI))
                channel_frequency_word[23:16] <= reg_wdata;
            if (wr_at(OFF_TX_MOD))
                preemphasis_enable <= reg_wdata[BIT_PREEMP];
            if (wr_at(OFF_TX_PTR))
                tx_buffer_base <= reg_wdata;
            if (wr_at(OFF_RX_PTR))
                rx_buffer_base <= reg_wdata;
        end
    end

    // ----------------------------------------
    // Measurement readbacks
    // ----------------------------------------
    always_ff @(posedge core_clk)
    begin
        if (srst)
        begin
            input_power_readout  <= 8'h00;
            link_quality_readout <= 8'h00;
        end
        else if (clk_en && meas_valid)
        begin
            input_power_readout  <= rssi_dbm;
            link_quality_readout <= link_quality;
        end
    end

    // ----------------------------------------
    // Wake timer setup
    // ----------------------------------------
    always_ff @(posedge core_clk)
    begin
        if (srst)
        begin
            div_stage            <= RST_DIV;
            div_code             <= RST_DIV;
            sleep_retention_mode <= RST_SLEEP;
            timeout_wake_enable  <= 1'b0;
        end
        else if (clk_en)
        begin
            if (wr_at(OFF_DIV))
                div_stage <= reg_wdata[DIV_MSB:0];
            if (wr_at(OFF_SLEEP))
            begin
                div_code            <= div_stage;
                timeout_wake_enable <= reg_wdata[BIT_WAKE_EN];
                if (sleep_code_ok(reg_wdata[SLEEP_MSB:SLEEP_LSB]))
                    sleep_retention_mode <= reg_wdata[SLEEP_MSB:SLEEP_LSB];
            end
        end
    end

    always_ff @(posedge core_clk)
    begin
        if (srst)
            wake_prescale_ratio <= rcw_div_ratio(RST_DIV);
        else if (clk_en)
            wake_prescale_ratio <= rcw_div_ratio(div_code);
    end

    // High byte is only staged, so the timer never sees a half-new value
    always_ff @(posedge core_clk)
    begin
        if (srst)
        begin
            reload_hi_stage <= RST_RELOAD[15:8];
            wake_reload     <= RST_RELOAD;
        end
        else if (clk_en)
        begin
            if (wr_at(OFF_RLD_HI))
                reload_hi_stage <= reg_wdata;
            if (wr_at(OFF_RLD_LO))
                wake_reload <= {reload_hi_stage, reg_wdata};
        end
    end

    always_ff @(posedge core_clk)
    begin
        if (srst)
            rc_clock_calibrate_enable <= 1'b0;
        else if (clk_en && wr_at(OFF_WT_CTRL))
            rc_clock_calibrate_enable <= reg_wdata[BIT_CAL];
    end

    // ----------------------------------------
    // Timeout and cold start flags
    // ----------------------------------------
    // Timeout comes from the slow clock; edge taken after two stages
    always_ff @(posedge core_clk)
    begin
        if (srst)
            tmo_sync <= 3'h0;
        else if (clk_en)
            tmo_sync <= {tmo_sync[1:0], wake_timeout_in};
    end

    assign timeout_evt = tmo_sync[1] & ~tmo_sync[2];
    assign clear_flags = wr_at(OFF_WT_CTRL) && reg_wdata[BIT_FLAG_CLR];

    // A new timeout beats a clear in the same cycle
    always_ff @(posedge core_clk)
    begin
        if (srst)
        begin
            timeout_flag    <= 1'b0;
            cold_start_flag <= 1'b1;
        end
        else if (clk_en)
        begin
            if (timeout_evt)
                timeout_flag <= 1'b1;
            else if (clear_flags)
                timeout_flag <= 1'b0;
            if (clear_flags)
                cold_start_flag <= 1'b0;
        end
    end

    always_ff @(posedge core_clk)
    begin
        if (srst)
            wake_request <= 1'b0;
        else if (clk_en)
            wake_request <= timeout_evt && timeout_wake_enable;
    end

    // ----------------------------------------
    // Read port
    // ----------------------------------------
    // Write-only and unmapped offsets read zero; reserved bits read zero
    always_comb
    begin
        next_rdata = 8'h00;
        case (reg_addr)
            OFF_BUF_CFG:  next_rdata[BIT_DLY_OFF] = start_delay_off;
            OFF_RX_DLY:   next_rdata = receive_start_delay;
            OFF_TX_DLY:   next_rdata = transmit_start_delay;
            OFF_DLY_EXT:  next_rdata = start_delay_extension;
            OFF_PKT_FMT:  next_rdata = packet_format_select;
            OFF_FREQ_LO:  next_rdata = channel_frequency_word[7:0];
            OFF_FREQ_MID: next_rdata = channel_frequency_word[15:8];
            OFF_FREQ_HI:  next_rdata = channel_frequency_word[23:16];
            OFF_TX_MOD:   next_rdata = {controller_owned_bits, preemphasis_enable};
            OFF_PWR:      next_rdata = input_power_readout;
            OFF_LQI:      next_rdata = link_quality_readout;
            OFF_TX_PTR:   next_rdata = tx_buffer_base;
            OFF_RX_PTR:   next_rdata = rx_buffer_base;
            OFF_SLEEP:
            begin
                next_rdata[SLEEP_MSB:SLEEP_LSB] = sleep_retention_mode;
                next_rdata[BIT_WAKE_EN]         = timeout_wake_enable;
            end
            OFF_RLD_LO:   next_rdata = wake_reload[7:0];
            OFF_WT_CTRL:  next_rdata[BIT_CAL] = rc_clock_calibrate_enable;
            OFF_WT_STAT:
            begin
                next_rdata[BIT_TOFLAG] = timeout_flag;
                next_rdata[BIT_COLD]   = cold_start_flag;
            end
            default:      next_rdata = 8'h00;
        endcase
    end

    always_ff @(posedge core_clk)
    begin
        if (srst)
            reg_rdata <= 8'h00;
        else if (clk_en)
            reg_rdata <= reg_rd ? next_rdata : 8'h00;
    end

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    a_read_base : assert property (@(posedge core_clk) disable iff (srst)
        clk_en && reg_rd && reg_addr == OFF_TX_PTR |=> reg_rdata == $past(tx_buffer_base))
        else $error("transmit base read mismatch");
    a_div_staged : assert property (@(posedge core_clk) disable iff (srst)
        clk_en && wr_at(OFF_DIV) |=> $stable(div_code))
        else $error("prescaler applied before sleep config write");
    a_div_commit : assert property (@(posedge core_clk) disable iff (srst)
        clk_en && wr_at(OFF_SLEEP) |=> ##1 wake_prescale_ratio == rcw_div_ratio($past(div_stage, 2)))
        else $error("prescaler ratio not committed");
    a_reload_commit : assert property (@(posedge core_clk) disable iff (srst)
        clk_en && wr_at(OFF_RLD_LO) |=> wake_reload == {$past(reload_hi_stage), $past(reg_wdata)})
        else $error("reload not assembled on low byte write");
    a_reload_hold : assert property (@(posedge core_clk) disable iff (srst)
        clk_en && wr_at(OFF_RLD_HI) |=> $stable(wake_reload))
        else $error("reload changed on high byte write");
    a_flag_sets : assert property (@(posedge core_clk) disable iff (srst)
        clk_en && timeout_evt |=> timeout_flag)
        else $error("timeout flag missed an event");
    a_flag_clear : assert property (@(posedge core_clk) disable iff (srst)
        clk_en && clear_flags && !timeout_evt |=> !timeout_flag && !cold_start_flag)
        else $error("flags not cleared");
    a_wake_gate : assert property (@(posedge core_clk) disable iff (srst)
        wake_request |-> $past(timeout_wake_enable) && $past(timeout_evt))
        else $error("wake without enabled timeout");
    c_rx_start : cover property (@(posedge core_clk) disable iff (srst)
        receive_command ##[1:1000] rx_search_start);
    c_wake : cover property (@(posedge core_clk) disable iff (srst) wake_request);
    c_clear_race : cover property (@(posedge core_clk) disable iff (srst)
        clk_en && clear_flags && timeout_evt);
endmodule : rcw_regs

/* rcw_regs_tb_top.sv */
// Self-checking bench for the radio configuration and wake timer register bank
module rcw_regs_tb_top import rcw_pkg::*;;
    timeunit 1ns;
    timeprecision 1ns;
    logic core_clk = 0, srst = 1, clk_en = 1, reg_wr = 0, reg_rd = 0, meas_valid = 0;
    logic receive_command = 0, transmit_command = 0, wake_timeout_in = 0;
    logic [9:0] reg_addr = '0;
    logic [7:0] reg_wdata = '0, rssi_dbm = 8'hF0, link_quality = 8'h3C, reg_rdata, rv;
    logic [6:0] controller_owned_bits = 7'h2A;
    logic [7:0] packet_format_select, tx_buffer_base, rx_buffer_base;
    logic [23:0] channel_frequency_word;
    logic [16:0] wake_prescale_ratio;
    logic [15:0] wake_reload;
    logic [3:0] sleep_retention_mode;
    logic rx_search_start, tx_state_start, preemphasis_enable, timeout_wake_enable;
    logic rc_clock_calibrate_enable, wake_request, timeout_flag, cold_start_flag;
    int mismatches = 0, checked = 0, cnt;
    // Row layout: address, write flag, write data, expected read data
    localparam logic [26:0] ROWS [15] = '{
        {10'h109, 1'h0, 8'h00, 8'hC0}, {10'h10A, 1'h0, 8'h00, 8'hC0},
        {10'h10B, 1'h0, 8'h00, 8'h00}, {10'h300, 1'h0, 8'h00, 8'h80},
        {10'h301, 1'h0, 8'h00, 8'hA9}, {10'h302, 1'h0, 8'h00, 8'h03},
        {10'h306, 1'h1, 8'h00, 8'h54}, {10'h30C, 1'h1, 8'h11, 8'hF0},
        {10'h30D, 1'h0, 8'h00, 8'h3C}, {10'h314, 1'h0, 8'h00, 8'h80},
        {10'h315, 1'h1, 8'h44, 8'h44}, {10'h13E, 1'h1, 8'h02, 8'h02},
        {10'h13E, 1'h1, 8'h05, 8'h02}, {10'h317, 1'h1, 8'h8F, 8'h09},
        {10'h3FF, 1'h1, 8'h77, 8'h00}};
    localparam int SH [8] = '{0, 2, 3, 4, 7, 10, 13, 16};

    rcw_regs uut (.core_clk, .srst, .clk_en, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
        .receive_command, .transmit_command, .controller_owned_bits, .rssi_dbm, .link_quality,
        .meas_valid, .wake_timeout_in, .rx_search_start, .tx_state_start, .packet_format_select,
        .channel_frequency_word, .preemphasis_enable, .tx_buffer_base, .rx_buffer_base,
        .wake_prescale_ratio, .sleep_retention_mode, .timeout_wake_enable, .wake_reload,
        .rc_clock_calibrate_enable, .wake_request, .timeout_flag, .cold_start_flag);

    initial
    begin
        forever #10 core_clk = ~core_clk;
    end

    // ----------------------------------------
    // Bus and check helpers
    // ----------------------------------------
    task automatic report_and_stop;
        if (mismatches == 0 && checked > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : report_and_stop

    task automatic chk(input string n, input logic [23:0] e, input logic [23:0] g);
        checked++;
        if (e !== g)
        begin
            mismatches++;
            $display("CHECK FAILED %s expected %h seen %h", n, e, g);
        end
    endtask : chk

    task automatic wr(input logic [9:0] a, input logic [7:0] d);
        @(posedge core_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge core_clk);
        reg_wr <= 1'b0;
        #1;
    endtask : wr

    task automatic rd(input logic [9:0] a, output logic [7:0] d);
        @(posedge core_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge core_clk);
        reg_rd <= 1'b0;
        #1 d = reg_rdata;
    endtask : rd

    // Counts cycles from the edge that takes the command to the start pulse
    task automatic go_wait(input logic tx, input int exp);
        @(posedge core_clk);
        transmit_command <= tx;
        receive_command <= !tx;
        @(posedge core_clk);
        transmit_command <= 1'b0;
        receive_command <= 1'b0;
        #1;
        // A bypassed start pulses right after the taking edge, so look before waiting
        for (cnt = 0; cnt < 400; cnt++)
        begin
            if ((tx ? tx_state_start : rx_search_start) === 1'b1) break;
            @(posedge core_clk) #1;
        end
        chk("start delay", 24'(exp), 24'(cnt));
        if (cnt >= 400) report_and_stop();
    endtask : go_wait

    task automatic wait_flag;
        for (cnt = 0; cnt < 10 && timeout_flag !== 1'b1; cnt++) @(posedge core_clk) #1;
        if (cnt >= 10) chk("flag wait", 24'h1, 24'h0);
        if (cnt >= 10) report_and_stop();
    endtask : wait_flag

    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial
    begin
        repeat (20) @(posedge core_clk);
        srst <= 1'b0;
        meas_valid <= 1'b1;
        @(posedge core_clk);
        meas_valid <= 1'b0;
        #1 chk("cold start", 24'h1, 24'(cold_start_flag));
        for (int i = 0; i < 15; i++)
        begin
            if (ROWS[i][16]) wr(ROWS[i][26:17], ROWS[i][15:8]);
            rd(ROWS[i][26:17], rv);
            chk("read row", 24'(ROWS[i][7:0]), 24'(rv));
        end
        chk("format", 24'h2, 24'(packet_format_select));
        wr(10'h302, 8'h04);
        chk("freq word", 24'h04A980, channel_frequency_word);
        wr(10'h109, 8'h01);
        go_wait(1'b0, 50);
        wr(10'h10A, 8'h01);
        wr(10'h10B, 8'h01);
        go_wait(1'b1, 250);
        wr(10'h107, 8'h80);
        go_wait(1'b1, 0);
        wr(10'h316, 8'h05);
        // Wait long enough that a prescaler applied early would reach the ratio output
        repeat (2) @(posedge core_clk);
        #1 chk("ratio staged", 24'h1, 24'(wake_prescale_ratio));
        for (int i = 0; i < 8; i++)
        begin
            wr(10'h316, 8'(i));
            wr(10'h317, 8'h59);
            @(posedge core_clk) #1;
            chk("ratio", 24'(1) << SH[i], 24'(wake_prescale_ratio));
        end
        chk("sleep mode", 24'h17, 24'({sleep_retention_mode, timeout_wake_enable}));
        wr(10'h318, 8'hAB);
        chk("reload staged", 24'h0, 24'(wake_reload));
        wr(10'h319, 8'hCD);
        chk("reload", 24'hABCD, 24'(wake_reload));
        @(posedge core_clk) wake_timeout_in <= 1'b1;
        wait_flag();
        chk("wake", 24'h1, 24'(wake_request));
        rd(10'h31B, rv);
        chk("status", 24'h06, 24'(rv));
        wr(10'h31A, 8'h03);
        chk("clear", 24'h0, 24'({timeout_flag, cold_start_flag}));
        chk("calibrate", 24'h1, 24'(rc_clock_calibrate_enable));
        wr(10'h317, 8'h58);
        @(posedge core_clk) wake_timeout_in <= 1'b0;
        repeat (4) @(posedge core_clk);
        wake_timeout_in <= 1'b1;
        wait_flag();
        chk("no wake", 24'h0, 24'(wake_request));
        // A write while the clock enable is low must leave the register alone
        @(posedge core_clk) clk_en <= 1'b0;
        wr(10'h314, 8'h11);
        @(posedge core_clk) clk_en <= 1'b1;
        #1 chk("freeze", 24'h80, 24'(tx_buffer_base));
        @(posedge core_clk) srst <= 1'b1;
        repeat (2) @(posedge core_clk);
        srst <= 1'b0;
        #1 chk("reset bases", 24'h8000, 24'({tx_buffer_base, rx_buffer_base}));
        chk("reset flags", 24'h3, 24'({preemphasis_enable, cold_start_flag}));
        report_and_stop();
    end
endmodule : rcw_regs_tb_top
